// File: hdl/amh_pkg.sv
package amh_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ        = 200;
   localparam int T_SETUP_NS     = 30;
   localparam int T_STROBE_NS    = 150;
   localparam int T_HOLD_NS      = 20;
   localparam int T_PWR_RESET_NS = 1000;
   // least times, rounded up to whole cycles
   localparam int SETUP_CYC  = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLD_CYC   = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int PWR_RESET_CYC = (T_PWR_RESET_NS * CLK_MHZ + 999) / 1000;

   // ----------------------------------------------------------------
   // device register map (register_index values)
   // ----------------------------------------------------------------
   localparam logic [3:0] OFS_SECTOR_DATA_PORT       = 4'h0;
   localparam logic [3:0] OFS_ERROR_FLAGS            = 4'h1;
   localparam logic [3:0] OFS_SECTOR_COUNT           = 4'h2;
   localparam logic [3:0] OFS_LBA_BITS_0_7           = 4'h3;
   localparam logic [3:0] OFS_LBA_BITS_8_15          = 4'h4;
   localparam logic [3:0] OFS_LBA_BITS_16_23         = 4'h5;
   localparam logic [3:0] OFS_LBA_BITS_24_27         = 4'h6;
   localparam logic [3:0] OFS_COMMAND                = 4'h7;
   localparam logic [3:0] OFS_SECTOR_DATA_PORT_ALIAS = 4'h8;
   localparam logic [3:0] OFS_ERROR_FLAGS_ALIAS      = 4'hD;
   localparam logic [3:0] OFS_DEVICE_CONTROL         = 4'hE;
   localparam logic [7:0] DEVCTL_SOFT_RESET          = 8'h04;
   localparam int         SECTOR_BYTES               = 512;
   localparam int         MAX_SECTORS                = 256;

   // ----------------------------------------------------------------
   // controller state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_PWRUP  = 3'b000,
      ST_IDLE   = 3'b001,
      ST_SETUP  = 3'b010,
      ST_STROBE = 3'b011,
      ST_HOLD   = 3'b100
   } amh_state_t;

endpackage

// File: hdl/amh_host_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - 8-bit host drives only low lane, data on lines 0-7.
// - 16-bit-only host may tie lane enables; still decodes its window.
// - host reserves 2K with data port select, else 16 bytes.
// - host reads with output strobe, writes with write strobe.
// - later resets requested by soft reset write to device control.
// - 512-byte sectors pass in order through data register.
module amh_host_ctrl
   import amh_pkg::*;
#(
   parameter int DATA_W = 16
)(
   // clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              rstn_i,
   // user command port
   input  wire logic              cmd_valid_i,
   output logic                   cmd_ready_o,
   input  wire logic              cmd_write_i,
   input  wire logic              cmd_wide_i,
   input  wire logic              cmd_data_port_i,
   input  wire logic [3:0]        cmd_index_i,
   input  wire logic [DATA_W-1:0] cmd_wdata_i,
   // user read data
   output logic                   rd_valid_o,
   input  wire logic              rd_ready_i,
   output logic [DATA_W-1:0]      rd_data_o,
   // device pins
   output logic                   dev_reset_o,
   output logic                   low_lane_enable_n_o,
   output logic                   high_lane_enable_n_o,
   output logic                   out_enable_n_o,
   output logic                   write_enable_n_o,
   output logic [3:0]             register_index_o,
   output logic                   data_port_select_o,
   input  wire logic [DATA_W-1:0] data_lines_i,
   output logic [DATA_W-1:0]      data_lines_o,
   output logic                   data_lines_oe_o,
   input  wire logic              ready_busy_line_i,
   // status
   output logic                   dev_ready_o
);

   typedef struct packed {
      amh_state_t        st;
      logic [7:0]        cnt;
      logic              wr;
      logic              wide;
      logic [2:0]        rdy_sync;
      logic [DATA_W-1:0] din_s1;
      logic [DATA_W-1:0] din_s2;
      logic [DATA_W-1:0] din_s3;
      logic              rdy;
      logic              cmd_ready;
      logic              reset_pin;
      logic              ce_lo_n;
      logic              ce_hi_n;
      logic              oe_n;
      logic              we_n;
      logic [3:0]        idx;
      logic              dps;
      logic [DATA_W-1:0] dout;
      logic              doe;
      logic [DATA_W-1:0] buf0;
      logic [DATA_W-1:0] buf1;
      logic [1:0]        bcnt;
      logic              bvalid;
   } amh_regs_t;

   amh_regs_t s_r;
   amh_regs_t s_nxt;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [DATA_W-1:0] cap;
      logic              push;
      logic              pop;
      cap   = '0;
      push  = 1'b0;
      pop   = 1'b0;
      s_nxt = s_r;

      // pins from outside pass three flops; a change counts once the
      // second and third stage agree, for the ready/busy line only; data is taken from the third stage as it stands
      s_nxt.rdy_sync = {s_r.rdy_sync[1:0], ready_busy_line_i};
      s_nxt.din_s1   = data_lines_i;
      s_nxt.din_s2   = s_r.din_s1;
      s_nxt.din_s3   = s_r.din_s2;
      if (s_r.rdy_sync[1] == s_r.rdy_sync[2])
      begin
         s_nxt.rdy = s_r.rdy_sync[2];
      end

      case (s_r.st)
         ST_PWRUP:
         begin
            // reset pin is only honoured around power-on
            s_nxt.reset_pin = 1'b1;
            if (s_r.cnt == 8'(PWR_RESET_CYC - 1))
            begin
               s_nxt.reset_pin = 1'b0;
               s_nxt.cnt       = '0;
               s_nxt.st        = ST_IDLE;
            end
            else
            begin
               s_nxt.cnt = s_r.cnt + 8'h01;
            end
         end
         ST_IDLE:
         begin
            if (cmd_valid_i && s_r.cmd_ready)
            begin
               s_nxt.wr   = cmd_write_i;
               s_nxt.wide = cmd_wide_i;
               s_nxt.dps  = cmd_data_port_i;
               s_nxt.idx  = cmd_index_i;
               if (cmd_wide_i)
               begin
                  // both lanes: bit zero is meaningless, hold it low
                  s_nxt.idx[0]  = 1'b0;
                  s_nxt.ce_hi_n = 1'b0;
                  s_nxt.dout    = cmd_wdata_i;
               end
               else
               begin
                  // narrow access rides on the low lane, lines 0-7
                  s_nxt.ce_hi_n = 1'b1;
                  s_nxt.dout    = {{(DATA_W-8){1'b0}}, cmd_wdata_i[7:0]};
               end
               s_nxt.ce_lo_n = 1'b0;
               s_nxt.doe     = cmd_write_i;
               s_nxt.cnt     = '0;
               s_nxt.st      = ST_SETUP;
            end
         end
         ST_SETUP:
         begin
            if (s_r.cnt == 8'(SETUP_CYC - 1))
            begin
               s_nxt.cnt  = '0;
               s_nxt.oe_n = s_r.wr;
               s_nxt.we_n = ~s_r.wr;
               s_nxt.st   = ST_STROBE;
            end
            else
            begin
               s_nxt.cnt = s_r.cnt + 8'h01;
            end
         end
         ST_STROBE:
         begin
            if (s_r.cnt == 8'(STROBE_CYC - 1))
            begin
               // one strobe, one capture
               s_nxt.cnt  = '0;
               s_nxt.oe_n = 1'b1;
               s_nxt.we_n = 1'b1;
               s_nxt.st   = ST_HOLD;
               if (!s_r.wr)
               begin
                  push = 1'b1;
                  cap  = s_r.wide ? s_r.din_s3
                                  : {{(DATA_W-8){1'b0}}, s_r.din_s3[7:0]};
               end
            end
            else
            begin
               s_nxt.cnt = s_r.cnt + 8'h01;
            end
         end
         ST_HOLD:
         begin
            if (s_r.cnt == 8'(HOLD_CYC - 1))
            begin
               s_nxt.cnt     = '0;
               s_nxt.ce_lo_n = 1'b1;
               s_nxt.ce_hi_n = 1'b1;
               s_nxt.doe     = 1'b0;
               s_nxt.dps     = 1'b0;
               s_nxt.st      = ST_IDLE;
            end
            else
            begin
               s_nxt.cnt = s_r.cnt + 8'h01;
            end
         end
         default:
         begin
            s_nxt.st = ST_IDLE;
         end
      endcase

      // ----------------------------------------------------------------
      // two-entry read buffer, head always in buf0
      // ----------------------------------------------------------------
      pop = s_r.bvalid && rd_ready_i;
      if (pop)
      begin
         s_nxt.buf0 = s_r.buf1;
      end
      if (push)
      begin
         if (s_r.bcnt == 2'd0 || (s_r.bcnt == 2'd1 && pop))
         begin
            s_nxt.buf0 = cap;
         end
         else
         begin
            s_nxt.buf1 = cap;
         end
      end
      s_nxt.bcnt   = s_r.bcnt + {1'b0, push} - {1'b0, pop};
      s_nxt.bvalid = (s_nxt.bcnt != 2'd0);

      // a new access only when the device is ready and the read buffer
      // is empty; a stalled reader thus stalls the command side
      s_nxt.cmd_ready = (s_nxt.st == ST_IDLE) && s_nxt.rdy
                        && (s_nxt.bcnt == 2'd0)
                        && !(cmd_valid_i && s_r.cmd_ready);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i)
   begin
      if (!rstn_i)
      begin
         s_r         <= '0;
         s_r.st      <= ST_PWRUP;
         s_r.ce_lo_n <= 1'b1;
         s_r.ce_hi_n <= 1'b1;
         s_r.oe_n    <= 1'b1;
         s_r.we_n    <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign cmd_ready_o          = s_r.cmd_ready;
   assign rd_valid_o           = s_r.bvalid;
   assign rd_data_o            = s_r.buf0;
   assign dev_reset_o          = s_r.reset_pin;
   assign low_lane_enable_n_o  = s_r.ce_lo_n;
   assign high_lane_enable_n_o = s_r.ce_hi_n;
   assign out_enable_n_o       = s_r.oe_n;
   assign write_enable_n_o     = s_r.we_n;
   assign register_index_o     = s_r.idx;
   assign data_port_select_o   = s_r.dps;
   assign data_lines_o         = s_r.dout;
   assign data_lines_oe_o      = s_r.doe;
   assign dev_ready_o          = s_r.rdy;

endmodule

// File: bench/amh_host_ctrl_checker.sv
`timescale 1ns/1ps
module amh_host_ctrl_checker (
   // clock, reset, command side
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic cmd_valid_i,
   input wire logic cmd_ready_o,
   input wire logic cmd_write_i,
   input wire logic cmd_wide_i,
   input wire logic rd_valid_o,
   // device pins
   input wire logic dev_reset_o,
   input wire logic low_lane_enable_n_o,
   input wire logic high_lane_enable_n_o,
   input wire logic out_enable_n_o,
   input wire logic write_enable_n_o,
   input wire logic data_lines_oe_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   wire tk = cmd_valid_i && cmd_ready_o;
   wire rd = tk && !cmd_write_i;
   property p_excl; !out_enable_n_o |-> write_enable_n_o; endproperty
   a_excl: assert property (p_excl) else $error("strobes overlap");
   property p_drop; tk |=> !cmd_ready_o; endproperty
   a_drop: assert property (p_drop) else $error("taken twice");
   property p_wide;
      tk && cmd_wide_i |=> !low_lane_enable_n_o && !high_lane_enable_n_o;
   endproperty
   a_wide: assert property (p_wide) else $error("wide lanes");
   property p_nar;
      tk && !cmd_wide_i |=> !low_lane_enable_n_o && high_lane_enable_n_o;
   endproperty
   a_nar: assert property (p_nar) else $error("narrow lanes");
   property p_rd; rd |-> ##[6:8] !out_enable_n_o; endproperty
   a_rd: assert property (p_rd) else $error("read strobe late");
   property p_ans; rd |-> ##[37:40] rd_valid_o; endproperty
   a_ans: assert property (p_ans) else $error("read answer late");
   property p_woe; !write_enable_n_o |-> data_lines_oe_o; endproperty
   a_woe: assert property (p_woe) else $error("write undriven");
   property p_rst; dev_reset_o |-> out_enable_n_o && write_enable_n_o;
   endproperty
   a_rst: assert property (p_rst) else $error("strobe in reset");
   property p_boot; dev_reset_o |-> !cmd_ready_o && low_lane_enable_n_o;
   endproperty
   a_boot: assert property (p_boot) else $error("access in reset");
   c_rd: cover property (rd);
   c_wr: cover property (tk && cmd_write_i);
   c_pwr: cover property ($fell(dev_reset_o));
endmodule
bind amh_host_ctrl amh_host_ctrl_checker u_chk (
   .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i),
   .cmd_ready_o(cmd_ready_o), .cmd_write_i(cmd_write_i),
   .cmd_wide_i(cmd_wide_i), .rd_valid_o(rd_valid_o),
   .dev_reset_o(dev_reset_o), .low_lane_enable_n_o(low_lane_enable_n_o),
   .high_lane_enable_n_o(high_lane_enable_n_o),
   .out_enable_n_o(out_enable_n_o), .write_enable_n_o(write_enable_n_o),
   .data_lines_oe_o(data_lines_oe_o));

// File: bench/amh_dev_model.sv
`timescale 1ns/1ps
module amh_dev_model
   import amh_pkg::*;
#(
   parameter logic [7:0] ERR_VAL = 8'h5A
)(
   // host pins
   input  wire logic        reset_i,
   input  wire logic        ce_lo_n_i,
   input  wire logic        ce_hi_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   input  wire logic [3:0]  idx_i,
   input  wire logic        dps_i,
   input  wire logic [15:0] dq_i,
   // device answers
   output logic [15:0]      dq_o,
   output logic             rb_o
);
   logic [7:0]  regs [16];
   logic [15:0] strm, last, rd;
   logic        busy, wide, port, drv;
   logic [3:0]  lo, hi;
   assign wide = !ce_lo_n_i && !ce_hi_n_i;
   assign lo   = {idx_i[3:1], 1'b0};
   assign hi   = {idx_i[3:1], 1'b1};
   assign port = dps_i || (wide && lo[2:0] == 3'h0);
   assign rd   = port ? strm : wide ? {regs[hi], regs[lo]}
               : {8'hA5, regs[idx_i]};
   assign drv  = !oe_n_i && (!ce_lo_n_i || !ce_hi_n_i);
   // released bus shows the inverse, never a stale copy
   assign dq_o = drv ? rd : ~last;
   assign rb_o = !reset_i && !busy;
   always @(rd or drv)
      if (drv)
         last = rd;
   task automatic clr;
      for (int i = 0; i < 16; i++)
         regs[i] = 8'h00;
      regs[1]  = ERR_VAL;
      regs[13] = ERR_VAL;
      strm     = 16'h0000;
   endtask
   initial
   begin
      busy = 1'b0;
      last = 16'h0000;
      clr();
   end
   always @(posedge reset_i) clr();
   always @(posedge oe_n_i)
      if (port && !ce_lo_n_i)
         strm = strm + 16'h0001;
   always @(posedge we_n_i)
   begin
      if (wide)
      begin
         regs[lo] = dq_i[7:0];
         regs[hi] = dq_i[15:8];
      end
      else
         regs[idx_i] = dq_i[7:0];
      regs[1]  = ERR_VAL;
      regs[13] = ERR_VAL;
      if (idx_i == OFS_DEVICE_CONTROL && (dq_i[7:0] & DEVCTL_SOFT_RESET))
         clr();
      if (idx_i == OFS_DEVICE_CONTROL || idx_i == OFS_COMMAND)
      begin
         busy = 1'b1;
         #300 busy = 1'b0;
      end
   end
endmodule

// File: bench/amh_host_ctrl_bench.sv
`timescale 1ns/1ps
module amh_host_ctrl_bench
   import amh_pkg::*;
;
   logic        clk = 0, rstn = 0, vld = 0, wr = 0, wd = 0, dps = 0;
   logic        rrdy = 0;
   logic [3:0]  idx = 4'h0, ix_o;
   logic [15:0] wdat = 16'h0000, rd, dout, dq, bus;
   logic        rdy, rv, drst, cel, ceh, oen, wen, dps_o, doe, rb, drdy;
   int          checks = 0, n_mismatch = 0;
   assign bus = doe ? dout : dq;
   always #2.5 clk = ~clk;
   amh_host_ctrl u_dut (.ref_clk_i(clk), .rstn_i(rstn), .cmd_valid_i(vld),
      .cmd_ready_o(rdy), .cmd_write_i(wr), .cmd_wide_i(wd),
      .cmd_data_port_i(dps), .cmd_index_i(idx), .cmd_wdata_i(wdat),
      .rd_valid_o(rv), .rd_ready_i(rrdy), .rd_data_o(rd),
      .dev_reset_o(drst), .low_lane_enable_n_o(cel),
      .high_lane_enable_n_o(ceh), .out_enable_n_o(oen),
      .write_enable_n_o(wen), .register_index_o(ix_o),
      .data_port_select_o(dps_o), .data_lines_i(bus), .data_lines_o(dout),
      .data_lines_oe_o(doe), .ready_busy_line_i(rb), .dev_ready_o(drdy));
   amh_dev_model u_dev (.reset_i(drst), .ce_lo_n_i(cel), .ce_hi_n_i(ceh),
      .oe_n_i(oen), .we_n_i(wen), .idx_i(ix_o), .dps_i(dps_o), .dq_i(bus),
      .dq_o(dq), .rb_o(rb));
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, s);
      checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("mismatch %s exp %h got %h", nm, e, s);
      end
   endtask
   // one access; reads stall the result a few cycles before taking it
   task automatic acc(input logic w, k_wd, k_dps, input logic [3:0] k_ix,
                      input logic [15:0] d, e);
      int k;
      @(negedge clk);
      {wr, wd, dps, idx, wdat, vld} = {w, k_wd, k_dps, k_ix, d, 1'b1};
      for (k = 0; k < 3000 && rdy !== 1'b1; k++) @(negedge clk);
      chk("cmd_ready", 16'h0001, {15'h0000, rdy});
      @(negedge clk);
      vld = 1'b0;
      if (!w)
      begin
         for (k = 0; k < 100 && rv !== 1'b1; k++) @(negedge clk);
         repeat (4) @(negedge clk);
         chk("rd_valid", 16'h0001, {15'h0000, rv});
         chk("rd_data", e, rd);
         rrdy = 1'b1;
         @(negedge clk);
         rrdy = 1'b0;
      end
   endtask
   task automatic t_lba;
      acc(1, 1, 0, 4'h4, 16'hB2A1, 0);
      acc(1, 0, 0, 4'h3, 16'h005C, 0);
      acc(1, 0, 0, 4'h6, 16'h000E, 0);
      acc(1, 0, 0, 4'h2, 16'h0000, 0);
      acc(0, 0, 0, 4'h5, 0, 16'h00B2);
      acc(0, 1, 0, 4'h3, 0, 16'h5C00);
      acc(0, 1, 0, 4'h6, 0, 16'h000E);
      $display("test lba done");
   endtask
   task automatic t_err;
      acc(0, 0, 0, 4'h1, 0, 16'h005A);
      acc(0, 0, 0, 4'hD, 0, 16'h005A);
      acc(0, 1, 0, 4'hD, 0, 16'h5A00);
      $display("test err done");
   endtask
   task automatic t_data;
      acc(0, 1, 0, 4'h0, 0, 16'h0000);
      acc(0, 1, 0, 4'h8, 0, 16'h0001);
      acc(0, 1, 1, 4'h5, 0, 16'h0002);
      acc(0, 0, 1, 4'h3, 0, 16'h0003);
      $display("test data done");
   endtask
   task automatic t_soft;
      acc(1, 0, 0, OFS_DEVICE_CONTROL, 16'h0004, 0);
      repeat (45) @(negedge clk);
      chk("dev_ready", 16'h0000, {15'h0000, drdy});
      acc(0, 0, 0, 4'h3, 0, 16'h0000);
      chk("dev_reset", 16'h0000, {15'h0000, drst});
      $display("test soft done");
   endtask
   initial
   begin
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      repeat (10) @(negedge clk);
      chk("dev_reset", 16'h0001, {15'h0000, drst});
      t_lba;
      t_err;
      t_data;
      t_soft;
      wrap_up;
   end
   initial
   begin
      #30000;
      n_mismatch++;
      wrap_up;
   end
endmodule
